// *** src/vic_source_ctrl.sv ***
// vectored interrupt unit: source control, priority, vectoring and request outputs
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"
module vic_source_ctrl #(
  parameter int NUM_SRC = 32,
  parameter int SYS_LINES = 4,
  parameter int STACK_DEPTH = 8,
  parameter logic [31:0] EXT_MASK = 32'he000_0001,
  parameter bit HAS_FAST_PIN = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic fast_interrupt_pin_i,
  input wire logic [SYS_LINES-1:0] system_source_i,
  input wire logic [NUM_SRC-1:2] peripheral_source_i,
  input wire logic [`VIC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic fast_request_n_o,
  output logic standard_request_n_o,
  output logic wake_o
);
  import vic_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (NUM_SRC < 3 || NUM_SRC > 32) $error("source count must be 3 to 32");
    if (SYS_LINES < 1) $error("at least one system line");
    if (STACK_DEPTH < 8) $error("stack depth below priority count");
  end

  // source 0 always comes from a pin, so it is always synchronised
  localparam logic [31:0] EXT_ALL = EXT_MASK | 32'h0000_0001;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] ffe;
    logic gmsk;
    logic [NUM_SRC-1:0][2:0] prio;
    logic [NUM_SRC-1:0][1:0] trig;
    logic [NUM_SRC-1:0][31:0] svr;
    logic [31:0] spu;
    logic [31:0] rdata;
    logic fast_n;
    logic std_n;
    logic wake;
  } vic_state_s;
  vic_state_s q;
  vic_state_s d;

  typedef struct packed {
    logic ok;
    vic_entry_s ent;
  } vic_best_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit_array(input logic [`VIC_ADDR_W-1:0] a,
                                     input logic [`VIC_ADDR_W-1:0] base);
    hit_array = (a[`VIC_ADDR_W-1:7] == base[`VIC_ADDR_W-1:7]) &&
                (32'(a[6:2]) < NUM_SRC) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] widen(input logic [NUM_SRC-1:0] v);
    widen = 32'(v);
  endfunction

  // highest level, lowest number on a tie
  function automatic vic_best_s pick_best(input logic [NUM_SRC-1:0] cand,
                                          input logic [NUM_SRC-1:0][2:0] pr);
    vic_best_s b;
    b = '0;
    for (int i = 1; i < NUM_SRC; i++) begin
      if (cand[i] && (!b.ok || pr[i] > b.ent.prio)) begin
        b.ok = 1'b1;
        b.ent.src = vic_src_t'(i);
        b.ent.prio = pr[i];
      end
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // source conditioning
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] sw_set;
  logic [NUM_SRC-1:0] sw_clr;
  logic [NUM_SRC-1:0] auto_clr;

  assign raw = {peripheral_source_i, |system_source_i, fast_interrupt_pin_i & HAS_FAST_PIN};

  vic_src_cond #(
    .NUM(NUM_SRC),
    .EXT_MASK(EXT_ALL)
  ) u_cond (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(raw),
    .trig_i(q.trig),
    .set_i(sw_set),
    .clr_i(sw_clr),
    .aclr_i(auto_clr),
    .pend_o(pend)
  );

  // ---------------------------------------------------------------
  // priority and nesting
  // ---------------------------------------------------------------
  logic push;
  logic pop;
  logic stk_valid;
  vic_entry_s stk_top;
  vic_best_s best;
  logic [NUM_SRC-1:0] std_cand;
  logic [NUM_SRC-1:0] fast_set;
  logic irq_req;
  logic fiq_req;

  // disabled sources never reach the arbiter
  assign std_cand = pend & q.mask & ~fast_set;
  // fast forced sources go to the fast line
  assign fast_set = q.ffe | {{(NUM_SRC-1){1'b0}}, 1'b1};
  assign fiq_req = |(pend & q.mask & fast_set);
  assign best = pick_best(std_cand, q.prio);
  // only a strictly higher level interrupts the one in service
  assign irq_req = best.ok && (!stk_valid || best.ent.prio > stk_top.prio);

  logic rd_ivr;
  logic rd_fvr;
  assign rd_ivr = rd_i && (addr_i == `VIC_OFF_IVR);
  assign rd_fvr = rd_i && (addr_i == `VIC_OFF_FVR);
  // nest on vector read, unwind on end of service
  assign push = rd_ivr && best.ok;
  assign pop = wr_i && (addr_i == `VIC_OFF_EOICR);

  vic_prio_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .push_i(push),
    .pop_i(pop),
    .entry_i(best.ent),
    .top_o(stk_top),
    .valid_o(stk_valid)
  );

  // ---------------------------------------------------------------
  // command strobes into the input stage
  // ---------------------------------------------------------------
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    auto_clr = '0;
    // software set and clear, level sources ignore them downstream
    if (wr_i && addr_i == `VIC_OFF_ISCR) begin
      sw_set = wdata_i[NUM_SRC-1:0];
    end
    if (wr_i && addr_i == `VIC_OFF_ICCR) begin
      sw_clr = wdata_i[NUM_SRC-1:0];
    end
    // only the chosen source, never a fast forced one
    if (push) begin
      auto_clr[best.ent.src] = 1'b1;
    end
    // fast vector read clears source 0
    if (rd_fvr) begin
      auto_clr[0] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers, read data and outputs
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    if (wr_i) begin
      if (addr_i == `VIC_OFF_IECR) begin
        d.mask = q.mask | wdata_i[NUM_SRC-1:0];
      end else if (addr_i == `VIC_OFF_IDCR) begin
        d.mask = q.mask & ~wdata_i[NUM_SRC-1:0];
      end else if (addr_i == `VIC_OFF_FFER) begin
        d.ffe = q.ffe | wdata_i[NUM_SRC-1:0];
      end else if (addr_i == `VIC_OFF_FFDR) begin
        d.ffe = q.ffe & ~wdata_i[NUM_SRC-1:0];
      end else if (addr_i == `VIC_OFF_DCR) begin
        d.gmsk = wdata_i[`VIC_DCR_GMSK];
      end else if (addr_i == `VIC_OFF_SPU) begin
        d.spu = wdata_i;
      end else if (hit_array(addr_i, `VIC_OFF_SMR)) begin
        // mode field: trigger condition and priority level
        d.prio[addr_i[6:2]] = wdata_i[`VIC_SMR_PRIO_LSB +: 3];
        d.trig[addr_i[6:2]] = wdata_i[`VIC_SMR_TYPE_LSB +: 2];
      end else if (hit_array(addr_i, `VIC_OFF_SVR)) begin
        d.svr[addr_i[6:2]] = wdata_i;
      end
    end
    // source 0 stays off without a fast pin; it is fast anyway
    d.mask[0] = d.mask[0] & HAS_FAST_PIN;
    d.ffe[0] = 1'b0;

    // read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (rd_i) begin
      if (rd_ivr) begin
        // handler address of the current source, else spurious
        d.rdata = best.ok ? q.svr[best.ent.src] : q.spu;
      end else if (rd_fvr) begin
        d.rdata = q.svr[0];
      end else if (addr_i == `VIC_OFF_ISR) begin
        d.rdata = stk_valid ? 32'(stk_top.src) : 32'h0;
      end else if (addr_i == `VIC_OFF_IPR) begin
        d.rdata = widen(pend);
      end else if (addr_i == `VIC_OFF_IMR) begin
        d.rdata = widen(q.mask);
      end else if (addr_i == `VIC_OFF_FFSR) begin
        d.rdata = widen(q.ffe);
      end else if (addr_i == `VIC_OFF_CISR) begin
        d.rdata[`VIC_CISR_FAST] = ~q.fast_n;
        d.rdata[`VIC_CISR_STD] = ~q.std_n;
      end else if (addr_i == `VIC_OFF_DCR) begin
        d.rdata[`VIC_DCR_GMSK] = q.gmsk;
      end else if (addr_i == `VIC_OFF_SPU) begin
        d.rdata = q.spu;
      end else if (hit_array(addr_i, `VIC_OFF_SMR)) begin
        d.rdata[`VIC_SMR_PRIO_LSB +: 3] = q.prio[addr_i[6:2]];
        d.rdata[`VIC_SMR_TYPE_LSB +: 2] = q.trig[addr_i[6:2]];
      end else if (hit_array(addr_i, `VIC_OFF_SVR)) begin
        d.rdata = q.svr[addr_i[6:2]];
      end
    end

    // active-low requests, held high under the global mask
    d.fast_n = ~(fiq_req & ~q.gmsk);
    // the standard line returns high as soon as a read has taken the source
    d.std_n = ~(irq_req & ~push & ~q.gmsk);
    // wake follows either request, even when masked
    d.wake = fiq_req | (irq_req & ~push);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q.mask <= '0;
      q.ffe <= '0;
      q.gmsk <= 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
        q.prio[i] <= `VIC_RST_PRIO;
        q.trig[i] <= `VIC_RST_TRIG;
        q.svr[i] <= '0;
      end
      q.spu <= `VIC_RST_SPU;
      q.rdata <= '0;
      q.fast_n <= 1'b1;
      q.std_n <= 1'b1;
      q.wake <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign fast_request_n_o = q.fast_n;
  assign standard_request_n_o = q.std_n;
  assign wake_o = q.wake;
endmodule
`default_nettype wire

// *** src/vic_defines.svh ***
// register offsets, field positions and reset values of the interrupt source control
//
// Notes on behaviour
// - up to 32 individually maskable sources, eight priority levels, vectored handlers
// - two active-low request outputs: fast and standard
// - internal sources are level or edge, polarity not user visible
// - external sources: rising edge, falling edge, high level or low level
// - per-source mode field picks the active condition
// - fast forcing routes a source to the fast request instead
// - single always-running clock, no gating dependence
// - any request assertion also raises the wake-up output
// - global mask keeps request lines high but still wakes
// - source 0 is the fast pin, unusable without that pin
// - source 1 is the OR of all system peripheral lines
// - sources 2 to 31 come from peripherals or external lines
// - enable and disable command registers, mask readable
// - a disabled source affects no other source
// - set and clear commands latch or drop an edge source
// - set and clear have no effect on level sources
// - standard vector read clears only the current source's edge
// - no auto clear for fast forced sources
// - fast vector read clears the edge of source 0
// - three-bit priority, 7 highest, 0 lowest
// - equal priority: lowest source number wins
// - equal or lower priority waits for end of service
// - eight-entry stack of source and priority, push on read, pop on end
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_ADDR_W 9
`define VIC_OFF_SMR 9'h000
`define VIC_OFF_SVR 9'h080
`define VIC_OFF_IVR 9'h100
`define VIC_OFF_FVR 9'h104
`define VIC_OFF_ISR 9'h108
`define VIC_OFF_IPR 9'h10c
`define VIC_OFF_IMR 9'h110
`define VIC_OFF_CISR 9'h114
`define VIC_OFF_IECR 9'h120
`define VIC_OFF_IDCR 9'h124
`define VIC_OFF_ICCR 9'h128
`define VIC_OFF_ISCR 9'h12c
`define VIC_OFF_EOICR 9'h130
`define VIC_OFF_SPU 9'h134
`define VIC_OFF_DCR 9'h138
`define VIC_OFF_FFER 9'h140
`define VIC_OFF_FFDR 9'h144
`define VIC_OFF_FFSR 9'h148

`define VIC_SMR_PRIO_LSB 0
`define VIC_SMR_TYPE_LSB 5
`define VIC_DCR_GMSK 1
`define VIC_CISR_FAST 0
`define VIC_CISR_STD 1
`define VIC_RST_SPU 32'h0000_0000
`define VIC_RST_TRIG 2'h0
`define VIC_RST_PRIO 3'h0

`endif

// *** src/vic_pkg.sv ***
// types shared by the interrupt source control modules
package vic_pkg;
  typedef logic [4:0] vic_src_t;
  typedef logic [2:0] vic_prio_t;
  // bit 0 set means edge, bit 1 set means high or rising
  typedef enum logic [1:0] {
    VIC_LOW_LEVEL = 2'h0,
    VIC_FALL_EDGE = 2'h1,
    VIC_HIGH_LEVEL = 2'h2,
    VIC_RISE_EDGE = 2'h3
  } vic_trig_e;
  typedef struct packed {
    vic_src_t src;
    vic_prio_t prio;
  } vic_entry_s;
endpackage

// *** src/vic_src_cond.sv ***
// input stage: synchroniser, condition detection and edge memory per source
`timescale 1ns/1ps
`default_nettype none
module vic_src_cond #(
  parameter int NUM = 32,
  parameter logic [31:0] EXT_MASK = 32'h0000_0001
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [NUM-1:0] src_i,
  input wire logic [NUM-1:0][1:0] trig_i,
  input wire logic [NUM-1:0] set_i,
  input wire logic [NUM-1:0] clr_i,
  input wire logic [NUM-1:0] aclr_i,
  output logic [NUM-1:0] pend_o
);
  import vic_pkg::*;
  typedef struct packed {
    logic [NUM-1:0] s1;
    logic [NUM-1:0] s2;
    logic [NUM-1:0] prev;
    logic [NUM-1:0] lat;
  } vic_cond_s;
  vic_cond_s q;
  vic_cond_s d;
  logic [NUM-1:0] act;

  always_comb begin
    d = q;
    d.s1 = src_i & EXT_MASK[NUM-1:0];
    d.s2 = q.s1;
    for (int i = 0; i < NUM; i++) begin
      if (EXT_MASK[i]) begin
        act[i] = trig_i[i][1] ? q.s2[i] : ~q.s2[i];
      end else begin
        act[i] = src_i[i];
      end
      d.prev[i] = act[i];
      if (trig_i[i][0]) begin
        d.lat[i] = (q.lat[i] & ~clr_i[i] & ~aclr_i[i]) | (act[i] & ~q.prev[i]) | set_i[i];
      end else begin
        d.lat[i] = 1'b0;
      end
      pend_o[i] = trig_i[i][0] ? q.lat[i] : act[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// *** src/vic_prio_stack.sv ***
// hardware stack of current source number and priority level
`timescale 1ns/1ps
`default_nettype none
module vic_prio_stack #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire vic_pkg::vic_entry_s entry_i,
  output vic_pkg::vic_entry_s top_o,
  output logic valid_o
);
  import vic_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    vic_entry_s [DEPTH-1:0] ent;
    logic [CW-1:0] cnt;
  } vic_stack_s;
  vic_stack_s q;
  vic_stack_s d;

  initial begin
    if (DEPTH < 8) $error("stack must hold one entry per priority level");
  end

  // push and pop, entry 0 is the top
  always_comb begin
    d = q;
    if (push_i && q.cnt != CW'(DEPTH)) begin
      d.ent[0] = entry_i;
      for (int i = 1; i < DEPTH; i++) d.ent[i] = q.ent[i-1];
      d.cnt = q.cnt + 1'b1;
    end else if (pop_i && q.cnt != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) d.ent[i] = q.ent[i+1];
      d.ent[DEPTH-1] = '0;
      d.cnt = q.cnt - 1'b1;
    end
  end

  assign top_o = q.ent[0];
  assign valid_o = (q.cnt != '0);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// *** verification/vic_source_ctrl_chk.sv ***
// port checker for the interrupt source control, bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"
module vic_source_ctrl_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`VIC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic fast_request_n_o,
  input wire logic standard_request_n_o,
  input wire logic wake_o
);
  logic [31:0] mask_q;
  logic [31:0] ff_q;
  logic gm_q;
  // mirrors of the enable mask, fast forcing set and global mask
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_q <= 32'h0;
      ff_q <= 32'h0;
      gm_q <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `VIC_OFF_IECR: mask_q <= mask_q | wdata_i;
        `VIC_OFF_IDCR: mask_q <= mask_q & ~wdata_i;
        `VIC_OFF_FFER: ff_q <= ff_q | wdata_i;
        `VIC_OFF_FFDR: ff_q <= ff_q & ~wdata_i;
        `VIC_OFF_DCR: gm_q <= wdata_i[`VIC_DCR_GMSK];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wake_on_req_a: assert property (!(fast_request_n_o && standard_request_n_o) |-> wake_o)
    else $error("wake-up low while a request line is low");
  mask_read_a: assert property (rd_i && addr_i == `VIC_OFF_IMR |=> rdata_o == $past(mask_q))
    else $error("mask readback differs from enable history");
  global_mask_a: assert property (gm_q |=> fast_request_n_o && standard_request_n_o)
    else $error("request line low under global mask");
  fast_route_a: assert property ((mask_q & (ff_q | 32'h1)) == 32'h0 |=> fast_request_n_o)
    else $error("fast request without an enabled fast source");
  std_route_a: assert property ((mask_q & ~ff_q & ~32'h1) == 32'h0 |=> standard_request_n_o)
    else $error("standard request without an enabled standard source");
  vector_take_a: assert property (rd_i && addr_i == `VIC_OFF_IVR && !standard_request_n_o |=> standard_request_n_o)
    else $error("standard request still low after vector read");
  wonly_zero_a: assert property (rd_i && addr_i inside {`VIC_OFF_IECR, `VIC_OFF_IDCR, `VIC_OFF_ICCR,
    `VIC_OFF_ISCR, `VIC_OFF_EOICR} |=> rdata_o == 32'h0)
    else $error("command register read not zero");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  take_c: cover property (rd_i && addr_i == `VIC_OFF_IVR && !standard_request_n_o);
  fast_c: cover property (!fast_request_n_o);
  gm_wake_c: cover property (gm_q && wake_o);
endmodule
bind vic_source_ctrl vic_source_ctrl_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fast_request_n_o(fast_request_n_o),
  .standard_request_n_o(standard_request_n_o), .wake_o(wake_o));
`default_nettype wire

// *** verification/vic_core_model.sv ***
// processor core model: idles on command, leaves idle on wake-up or request
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire logic fast_request_n_i,
  input wire logic standard_request_n_i,
  input wire logic wake_i,
  output logic idle_o
);
  // wake or any low request ends idle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || wake_i || !fast_request_n_i || !standard_request_n_i) begin
      idle_o <= 1'b0;
    end else if (sleep_i) begin
      idle_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verification/test_vectored_irq_source_control.sv ***
// self-checking bench for the interrupt source control
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_vectored_irq_source_control;
  import vic_pkg::*;
  logic clk_sys_i, rst_i, fpin, wr_i, rd_i, sleep, idle, freq_n, sreq_n, wake;
  logic [3:0] system_source;
  logic [31:2] per;
  logic [8:0] addr_i;
  logic [31:0] wdata_i, rdata_o, v, r1;
  logic [31:0] vec [32];
  int n_mismatch = 0;
  int checked = 0;
  int t, p;
  vic_source_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fast_interrupt_pin_i(fpin), .system_source_i(system_source),
    .peripheral_source_i(per), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fast_request_n_o(freq_n), .standard_request_n_o(sreq_n), .wake_o(wake));
  vic_core_model core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sleep_i(sleep), .fast_request_n_i(freq_n),
    .standard_request_n_i(sreq_n), .wake_i(wake), .idle_o(idle));
  function automatic logic [8:0] smr(input int n);
    return `VIC_OFF_SMR + 9'(4 * n);
  endfunction
  function automatic logic [8:0] svr(input int n);
    return `VIC_OFF_SVR + 9'(4 * n);
  endfunction
  function automatic logic [31:0] mask_after(input logic [31:0] en, input logic [31:0] dis);
    return en & ~dis;
  endfunction
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // bounded wait for a request line to reach a level
  task automatic wreq(input bit f, input logic e);
    for (int i = 0; i < 24 && (f ? freq_n : sreq_n) !== e; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // the run needs a few hundred cycles; far beyond that means a hang
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_i = 1'b1;
    {fpin, wr_i, rd_i, sleep, system_source, per, addr_i, wdata_i} = '0;
    v = $urandom(32'haa0d);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`VIC_OFF_IVR, v);
    `CHK("spurious", 32'h0, v)
    `CHK("req idle", 1'b1, freq_n & sreq_n)
    r1 = $urandom;
    v = $urandom;
    wr(`VIC_OFF_IECR, r1);
    wr(`VIC_OFF_IDCR, v);
    r1 = mask_after(r1, v);
    rd(`VIC_OFF_IMR, v);
    `CHK("imr", r1, v)
    wr(`VIC_OFF_IDCR, 32'hffff_ffff);
    for (t = 0; t < 32; t++) begin
      vec[t] = $urandom;
      wr(svr(t), vec[t]);
    end
    // --------------------------------
    // internal level source
    // --------------------------------
    p = $urandom_range(7, 0);
    wr(smr(5), 32'(p));
    wr(`VIC_OFF_IECR, 32'h20);
    @(posedge clk_sys_i);
    per[5] <= 1'b1;
    wreq(0, 1'b0);
    `CHK("lvl req", 1'b0, sreq_n)
    rd(`VIC_OFF_IVR, v);
    `CHK("lvl vec", vec[5], v)
    `CHK("in service", 1'b1, sreq_n)
    wr(`VIC_OFF_ICCR, 32'h20);
    rd(`VIC_OFF_IPR, v);
    `CHK("lvl clr", 1'b1, v[5])
    wr(`VIC_OFF_EOICR, 32'h0);
    wreq(0, 1'b0);
    `CHK("after eoi", 1'b0, sreq_n)
    @(posedge clk_sys_i);
    per[5] <= 1'b0;
    wr(`VIC_OFF_IDCR, 32'h20);
    wr(`VIC_OFF_ISCR, 32'h20);
    rd(`VIC_OFF_IPR, v);
    `CHK("lvl set", 1'b0, v[5])
    // equal priority tie, nesting, and a disabled active source beside them
    p = $urandom_range(6, 0);
    wr(smr(9), 32'h20 | 32'(p));
    wr(smr(12), 32'h20 | 32'(p));
    wr(smr(14), 32'h21 + 32'(p));
    wr(smr(20), 32'h7);
    @(posedge clk_sys_i);
    per[20] <= 1'b1;
    wr(`VIC_OFF_IECR, 32'h5200);
    wr(`VIC_OFF_ISCR, 32'h1200);
    wreq(0, 1'b0);
    rd(`VIC_OFF_IVR, v);
    `CHK("tie vec", vec[9], v)
    rd(`VIC_OFF_IPR, v);
    `CHK("auto clr", 4'h8, v[12:9])
    wr(`VIC_OFF_ISCR, 32'h4000);
    wreq(0, 1'b0);
    rd(`VIC_OFF_IVR, v);
    `CHK("nest vec", vec[14], v)
    rd(`VIC_OFF_ISR, v);
    `CHK("stack top", 32'd14, v)
    wr(`VIC_OFF_EOICR, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK("equal held", 1'b1, sreq_n)
    wr(`VIC_OFF_EOICR, 32'h0);
    wreq(0, 1'b0);
    rd(`VIC_OFF_IVR, v);
    `CHK("popped vec", vec[12], v)
    wr(`VIC_OFF_EOICR, 32'h0);
    wr(`VIC_OFF_ISCR, 32'h200);
    wr(`VIC_OFF_ICCR, 32'h200);
    rd(`VIC_OFF_IPR, v);
    `CHK("sw clr", 1'b0, v[9])
    @(posedge clk_sys_i);
    per[20] <= 1'b0;
    wr(`VIC_OFF_IDCR, 32'hffff_ffff);
    // fast forcing of an edge source
    wr(smr(3), 32'h27);
    wr(`VIC_OFF_FFER, 32'h8);
    wr(`VIC_OFF_IECR, 32'h8);
    wr(`VIC_OFF_ISCR, 32'h8);
    wreq(1, 1'b0);
    `CHK("forced fast", 1'b0, freq_n)
    `CHK("forced std", 1'b1, sreq_n)
    rd(`VIC_OFF_IVR, v);
    `CHK("no std vec", 32'h0, v)
    rd(`VIC_OFF_IPR, v);
    `CHK("forced kept", 1'b1, v[3])
    wr(`VIC_OFF_ICCR, 32'h8);
    wr(`VIC_OFF_FFDR, 32'h8);
    wr(`VIC_OFF_IDCR, 32'h8);
    // fast pin on source zero
    wr(smr(0), 32'h60);
    wr(`VIC_OFF_IECR, 32'h1);
    @(posedge clk_sys_i);
    fpin <= 1'b1;
    wreq(1, 1'b0);
    `CHK("pin fast", 1'b0, freq_n)
    rd(`VIC_OFF_FVR, v);
    `CHK("fvr vec", vec[0], v)
    wreq(1, 1'b1);
    `CHK("fvr clr", 1'b1, freq_n)
    wr(`VIC_OFF_IDCR, 32'h1);
    // all four external conditions; two cycles in, the synchroniser still hides the event
    for (t = 0; t < 4; t++) begin
      wr(smr(30), {25'h0, t[1:0], 5'h2});
      @(posedge clk_sys_i);
      per[30] <= ~t[1];
      repeat (4) @(posedge clk_sys_i);
      wr(`VIC_OFF_ICCR, 32'h4000_0000);
      wr(`VIC_OFF_IECR, 32'h4000_0000);
      @(posedge clk_sys_i);
      per[30] <= t[1];
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK("sync delay", 1'b1, sreq_n)
      wreq(0, 1'b0);
      rd(`VIC_OFF_IVR, v);
      `CHK("ext vec", vec[30], v)
      @(posedge clk_sys_i);
      per[30] <= ~t[1];
      wr(`VIC_OFF_EOICR, 32'h0);
      wr(`VIC_OFF_IDCR, 32'h4000_0000);
    end
    // global mask: each system line raises wake, the first wakes the idle core, request lines stay high
    wr(smr(1), 32'h1);
    wr(`VIC_OFF_IECR, 32'h2);
    wr(`VIC_OFF_DCR, 32'h2);
    @(posedge clk_sys_i);
    sleep <= 1'b1;
    @(posedge clk_sys_i);
    sleep <= 1'b0;
    for (t = 0; t < 4; t++) begin
      @(posedge clk_sys_i);
      system_source <= 4'(1 << t);
      repeat (4) @(posedge clk_sys_i);
      #1;
      `CHK("gm req", 1'b1, sreq_n)
      `CHK("gm wake", 1'b1, wake)
    end
    `CHK("core woke", 1'b0, idle)
    wr(`VIC_OFF_DCR, 32'h0);
    wreq(0, 1'b0);
    rd(`VIC_OFF_IVR, v);
    `CHK("sys vec", vec[1], v)
    wr(`VIC_OFF_EOICR, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
